/* axil_reg_port.sv */
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/10ps
`default_nettype none
module axil_reg_port
  import perf_mon_pkg::*;
(
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address and data.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // Write response.
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // Read address and data.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Register side.
  output logic                       wr_en,
  output logic [IDX_W-1:0]           wr_idx,
  output logic [7:0]                 wr_data,
  input  wire logic                  wr_err,
  output logic                       rd_en,
  output logic [IDX_W-1:0]           rd_idx,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_err
);

  logic aw_full_reg;
  logic w_full_reg;
  logic wstrb0_reg;
  logic do_write;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign do_write      = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wr_en         = do_write & wstrb0_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_en         = s_axi_arvalid & s_axi_arready;
  assign rd_idx        = s_axi_araddr[AXI_ADDR_W-1:2];

  // Address and data are caught independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      wstrb0_reg  <= 1'b0;
      wr_idx      <= '0;
      wr_data     <= 8'h00;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        wr_idx      <= s_axi_awaddr[AXI_ADDR_W-1:2];
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wr_data    <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response follows the register update.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is captured on the same edge that takes the address; rvalid rises on that edge too.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* e1_performance_monitor.sv */
// Per-link E1 performance monitor with snapshot readout over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module e1_performance_monitor
  import perf_mon_pkg::*;
#(
  parameter int NUM_LINKS     = 8,
  parameter int SECOND_CYCLES = SNAPSHOT_PERIOD_CYCLES
) (
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write channels.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Error events, one bit per link, one-cycle pulses.
  input  wire logic [NUM_LINKS-1:0]  line_violation_evt,
  input  wire logic [NUM_LINKS-1:0]  framing_error_evt,
  input  wire logic [NUM_LINKS-1:0]  crc4_error_evt,
  input  wire logic [NUM_LINKS-1:0]  far_block_error_evt,
  input  wire logic [NUM_LINKS-1:0]  align_shift_evt,
  input  wire logic [NUM_LINKS-1:0]  sync_loss_evt,
  input  wire logic [NUM_LINKS-1:0]  pattern_error_evt,
  input  wire logic [NUM_LINKS-1:0]  national_far_error_evt,
  input  wire logic [NUM_LINKS-1:0]  national_crc_error_evt,
  // Overflow interrupt, active high level.
  output logic                       overflow_irq
);

  localparam int SEC_W = $clog2(SECOND_CYCLES);

  if (NUM_LINKS < 1 || NUM_LINKS > 8) begin : g_bad_links
    $error("NUM_LINKS must be 1 to 8");
  end
  if (SECOND_CYCLES < 2) begin : g_bad_period
    $error("SECOND_CYCLES must be at least 2");
  end

  // Bus strobes.
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0]       wr_data;
  logic             wr_err;
  logic             rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0]      rd_data;
  logic             rd_err;

  // Software-visible state, and the last manual bit for edge detection.
  logic [6:0]         select_reg;
  logic [7:0]         readback_reg;
  logic [1:0]         ctrl_reg     [NUM_LINKS];
  logic               manual_prev  [NUM_LINKS];
  logic [NUM_CNT-1:0] en_reg       [NUM_LINKS];
  logic [NUM_CNT-1:0] flag_reg     [NUM_LINKS];

  // Counter plumbing.
  logic [SEC_W-1:0]   sec_cnt_reg;
  logic               sec_tick;
  logic               snapshot     [NUM_LINKS];
  logic [NUM_CNT-1:0] evt          [NUM_LINKS];
  logic [NUM_CNT-1:0] ovf          [NUM_LINKS];
  logic [127:0]       link_img     [NUM_LINKS];
  logic [NUM_LINKS-1:0] irq_link;

  // Write, read and select decode helpers.
  logic [2:0] wr_link;
  logic [7:0] wr_off;
  logic       wr_link_ok;
  logic [2:0] rd_link;
  logic [7:0] rd_off;
  logic       rd_link_ok;
  logic [2:0] sel_link;
  logic [3:0] sel_addr;

  axil_reg_port u_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_idx        (wr_idx),
    .wr_data       (wr_data),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Per-link register block repeats at a fixed stride, link n in page n.
  assign wr_link    = wr_idx[IDX_LINK_LSB +: 3];
  assign wr_off     = wr_idx[7:0];
  assign wr_link_ok = 32'(wr_link) < NUM_LINKS;
  assign rd_link    = rd_idx[IDX_LINK_LSB +: 3];
  assign rd_off     = rd_idx[7:0];
  assign rd_link_ok = 32'(rd_link) < NUM_LINKS;
  assign sel_link   = select_reg[SEL_LINK_LSB +: 3];
  assign sel_addr   = select_reg[SEL_ADDR_LSB +: 4];

  // Unmapped write addresses answer with an error and change nothing.
  always_comb begin
    wr_err = 1'b1;
    if (wr_idx == ACCESS_SELECT_IDX || wr_idx == ACCESS_READBACK_IDX) begin
      wr_err = 1'b0;
    end else if (wr_link_ok && wr_off >= UPDATE_CONTROL_OFF && wr_off <= FLAGS_HIGH_OFF) begin
      wr_err = 1'b0;
    end
  end

  // One-second tick shared by all links.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_reg <= '0;
    end else if (sec_tick) begin
      sec_cnt_reg <= '0;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + SEC_W'(1);
    end
  end

  assign sec_tick = sec_cnt_reg == SEC_W'(SECOND_CYCLES - 1);

  // Access select register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_reg <= SELECT_RST;
    end else if (wr_en && wr_idx == ACCESS_SELECT_IDX) begin
      select_reg <= wr_data[6:0];
    end
  end

  // Indirect readback byte, refreshed every cycle from the chosen snapshot.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      readback_reg <= 8'h00;
    end else if (32'(sel_link) < NUM_LINKS) begin
      readback_reg <= link_img[sel_link][{sel_addr, 3'h0} +: 8];
    end else begin
      readback_reg <= 8'h00;
    end
  end

  genvar l;
  genvar k;
  for (l = 0; l < NUM_LINKS; l++) begin : g_link
    // Event bits in counter order.
    assign evt[l] = {national_crc_error_evt[l], national_far_error_evt[l], pattern_error_evt[l],
                     sync_loss_evt[l], align_shift_evt[l], far_block_error_evt[l],
                     crc4_error_evt[l], framing_error_evt[l], line_violation_evt[l]};

    // Automatic tick or manual rising edge starts a snapshot.
    assign snapshot[l] = (ctrl_reg[l][CTRL_AUTO_BIT] & sec_tick)
                       | (ctrl_reg[l][CTRL_MANUAL_BIT] & ~manual_prev[l]);

    // Update control and enable registers of this link.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_reg[l]    <= CTRL_RST;
        manual_prev[l] <= 1'b0;
        en_reg[l]      <= EN_RST;
      end else begin
        manual_prev[l] <= ctrl_reg[l][CTRL_MANUAL_BIT];
        if (wr_en && wr_link == 3'(l)) begin
          if (wr_off == UPDATE_CONTROL_OFF) begin
            ctrl_reg[l] <= wr_data[1:0];
          end
          if (wr_off == IRQ_EN_LOW_OFF) begin
            en_reg[l][NUM_CNT-1:FLAG_HIGH_CNT] <= wr_data[FLAG_LOW_CNT-1:0];
          end
          if (wr_off == IRQ_EN_HIGH_OFF) begin
            en_reg[l][FLAG_HIGH_CNT-1:0] <= wr_data[FLAG_HIGH_CNT-1:0];
          end
        end
      end
    end

    // Sticky flags: a new overflow wins over a clear in the same cycle.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_reg[l] <= FLAG_RST;
      end else if (wr_en && wr_link == 3'(l) && wr_off == FLAGS_LOW_OFF) begin
        flag_reg[l] <= (flag_reg[l] & ~{wr_data[FLAG_LOW_CNT-1:0], {FLAG_HIGH_CNT{1'b0}}}) | ovf[l];
      end else if (wr_en && wr_link == 3'(l) && wr_off == FLAGS_HIGH_OFF) begin
        flag_reg[l] <= (flag_reg[l] & ~{{FLAG_LOW_CNT{1'b0}}, wr_data[FLAG_HIGH_CNT-1:0]}) | ovf[l];
      end else begin
        flag_reg[l] <= flag_reg[l] | ovf[l];
      end
    end

    // Enabled flags of this link feed the shared interrupt.
    assign irq_link[l] = |(flag_reg[l] & en_reg[l]);

    for (k = 0; k < NUM_CNT; k++) begin : g_cnt
      logic [SNAP_W-1:0] snap_value;

      perf_counter #(
        .W (CNT_W[k])
      ) u_cnt (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .event_in   (evt[l][k]),
        .snapshot   (snapshot[l]),
        .snap_value (snap_value),
        .overflow   (ovf[l][k])
      );

      // Snapshot placed at its readout locations, low byte first.
      assign link_img[l][CNT_LOC[k]*8 +: CNT_BYTES[k]*8] = snap_value[CNT_BYTES[k]*8-1:0];
    end
  end

  assign overflow_irq = |irq_link;

  // Register read multiplexer.
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (rd_idx == ACCESS_SELECT_IDX) begin
      rd_data = 32'(select_reg);
    end else if (rd_idx == ACCESS_READBACK_IDX) begin
      rd_data = 32'(readback_reg);
    end else if (rd_link_ok) begin
      unique case (rd_off)
        UPDATE_CONTROL_OFF: rd_data = 32'(ctrl_reg[rd_link]);
        IRQ_EN_LOW_OFF:     rd_data = 32'(en_reg[rd_link][NUM_CNT-1:FLAG_HIGH_CNT]);
        IRQ_EN_HIGH_OFF:    rd_data = 32'(en_reg[rd_link][FLAG_HIGH_CNT-1:0]);
        FLAGS_LOW_OFF:      rd_data = 32'(flag_reg[rd_link][NUM_CNT-1:FLAG_HIGH_CNT]);
        FLAGS_HIGH_OFF:     rd_data = 32'(flag_reg[rd_link][FLAG_HIGH_CNT-1:0]);
        default:            rd_err  = 1'b1;
      endcase
    end else begin
      rd_err = 1'b1;
    end
  end

endmodule
`default_nettype wire

/* e1_performance_monitor_properties.sv */
// Concurrent checks on the bus and interrupt ports of the performance monitor.
`timescale 1ns/10ps
`default_nettype none
module e1_performance_monitor_properties
  import perf_mon_pkg::*;
(
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Read channels.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Interrupt.
  input wire logic        overflow_irq
);
  // All checks run on the one clock and sleep during reset.
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Answers come within the promised cycles and stand until taken.
  a_write_answer_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  // Readback carries one byte only.
  a_rdata_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_bresp_known_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("unknown write response");
  // The interrupt only drops through a register write.
  a_irq_clear_by_write: assert property ($fell(overflow_irq) |-> s_axi_bvalid)
    else $error("interrupt dropped without a write");

  // Main scenarios.
  c_slave_error: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_irq_raised: cover property ($rose(overflow_irq));
  c_answer_waits: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind e1_performance_monitor e1_performance_monitor_properties u_e1_performance_monitor_properties (.*);
`default_nettype wire

/* e1_performance_monitor_test.sv */
// Self-checking testbench for the E1 performance monitor.
`timescale 1ns/10ps
`default_nettype none
module e1_performance_monitor_test;
  import perf_mon_pkg::*;
  localparam int SEC = 20;
  // Bus, clock and reset signals.
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0;
  logic [AXI_ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0]           s_axi_wdata = '0;
  logic [3:0]            s_axi_wstrb = 4'h1;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [31:0]           s_axi_rdata;
  logic                  overflow_irq;
  // Event lines, indexed by counter and then by link.
  logic [7:0]            ev [9] = '{default: 8'h00};
  wire logic [7:0]       line_violation_evt = ev[0], framing_error_evt = ev[1], crc4_error_evt = ev[2];
  wire logic [7:0]       far_block_error_evt = ev[3], align_shift_evt = ev[4], sync_loss_evt = ev[5];
  wire logic [7:0]       pattern_error_evt = ev[6], national_far_error_evt = ev[7], national_crc_error_evt = ev[8];
  int                    failures = 0, samples_checked = 0, n_hi = 0;

  e1_performance_monitor #(.SECOND_CYCLES(SEC)) u_e1_performance_monitor (.*);

  // Clock and a count of line events seen on link 3.
  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) if (ev[0][3]) n_hi <= n_hi + 1;

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task tally_and_finish;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Register write; the response is accepted late to exercise holding.
  task wr(input int a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= 13'(a * 4);
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task rd(input int a, input logic [1:0] er, output logic [31:0] v);
    s_axi_araddr <= 13'(a * 4);
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Indirect readout of one byte and of a two-byte counter.
  task pk(input int l, input int loc, output logic [31:0] v);
    wr(14, 8'(l * 16 + loc), RESP_OKAY);
    rd(15, RESP_OKAY, v);
  endtask

  task pk16(input int l, input int loc, output logic [31:0] v);
    logic [31:0] lo, hi;
    pk(l, loc, lo);
    pk(l, loc + 1, hi);
    v = {16'h0, hi[7:0], lo[7:0]};
  endtask

  task hold(input int k, input int l, input int n);
    ev[k][l] <= 1'b1;
    repeat (n) @(posedge aclk);
    ev[k][l] <= 1'b0;
  endtask

  task t_regs;
    logic [31:0] v;
    for (int o = 'hc2; o <= 'hc6; o++) begin
      rd(o, RESP_OKAY, v);
      chk(v, 32'h0);
    end
    wr(14, 8'h7a, RESP_OKAY);
    rd(14, RESP_OKAY, v);
    chk(v, 32'h7a);
    s_axi_wstrb <= 4'h0;
    wr(14, 8'h11, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd(14, RESP_OKAY, v);
    chk(v, 32'h7a);
    wr(15, 8'h55, RESP_OKAY);
    rd(15, RESP_OKAY, v);
    chk(v, 32'h0);
    rd('h10, RESP_SLVERR, v);
    wr('h10, 8'h01, RESP_SLVERR);
  endtask

  // Counter k on link 1 gets k+1 events; every location is then read.
  task t_map;
    int          loc [9] = '{8, 2, 0, 12, 4, 5, 6, 14, 10};
    logic [7:0]  e [16];
    logic [31:0] v;
    e = '{default: 8'h00};
    for (int k = 0; k < 9; k++) begin
      hold(k, 1, k + 1);
      e[loc[k]] = 8'(k + 1);
    end
    wr('h1c2, 8'h02, RESP_OKAY);
    for (int a = 0; a < 16; a++) begin
      pk(1, a, v);
      chk(v, {24'h0, e[a]});
      pk(0, a, v);
      chk(v, 32'h0);
    end
  endtask

  // Events keep coming across a manual snapshot; none may be lost.
  task t_coin;
    logic [31:0] a, b;
    ev[0][3] <= 1'b1;
    wr('h3c2, 8'h02, RESP_OKAY);
    repeat (3) @(posedge aclk);
    ev[0][3] <= 1'b0;
    pk16(3, 8, a);
    wr('h3c2, 8'h00, RESP_OKAY);
    wr('h3c2, 8'h02, RESP_OKAY);
    pk16(3, 8, b);
    chk(a + b, 32'(n_hi));
  endtask

  // A steady event on link 2 yields one period's worth per snapshot.
  task t_auto;
    logic [31:0] v;
    wr('h2c2, 8'h01, RESP_OKAY);
    ev[1][2] <= 1'b1;
    repeat (50) @(posedge aclk);
    pk16(2, 2, v);
    chk(v, 32'(SEC));
    ev[1][2] <= 1'b0;
    repeat (50) @(posedge aclk);
    pk16(2, 2, v);
    chk(v, 32'h0);
  endtask

  // Overflow of counter k on link 0, then enable, sticky flag and clear.
  task t_ovf(input int k, input int n, input int off, input logic [7:0] m);
    logic [31:0] v;
    hold(k, 0, n);
    repeat (3) @(posedge aclk);
    chk({31'h0, overflow_irq}, 32'h0);
    rd(off + 2, RESP_OKAY, v);
    chk(v, {24'h0, m});
    wr(off, m, RESP_OKAY);
    chk({31'h0, overflow_irq}, 32'h1);
    wr(off + 2, 8'h00, RESP_OKAY);
    rd(off + 2, RESP_OKAY, v);
    chk(v, {24'h0, m});
    wr(off + 2, m, RESP_OKAY);
    rd(off + 2, RESP_OKAY, v);
    chk(v, 32'h0);
    chk({31'h0, overflow_irq}, 32'h0);
    wr(off, 8'h00, RESP_OKAY);
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_map;
    t_coin;
    t_auto;
    t_ovf(4, 8, 'hc3, 8'h02);
    t_ovf(2, 1025, 'hc4, 8'h04);
    tally_and_finish;
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* perf_counter.sv */
// One saturating event counter with snapshot-and-clear.
`timescale 1ns/10ps
`default_nettype none
module perf_counter
  import perf_mon_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Event and snapshot strobe.
  input  wire logic              event_in,
  input  wire logic              snapshot,
  // Captured value and overflow pulse.
  output logic      [SNAP_W-1:0] snap_value,
  output logic                   overflow
);

  localparam logic [W-1:0] MAX = {W{1'b1}};

  logic [W-1:0] count_reg;

  if (W < 1 || W > SNAP_W) begin : g_bad_width
    $error("perf_counter width out of range");
  end

  // An event at the clear is kept as the first count of the new round.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (snapshot) begin
      count_reg <= W'(event_in);
    end else if (event_in && count_reg != MAX) begin
      count_reg <= count_reg + W'(1);
    end
  end

  // The snapshot holds the round just ended.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_value <= '0;
    end else if (snapshot) begin
      snap_value <= SNAP_W'(count_reg);
    end
  end

  // A full counter that sees one more event outside a snapshot overflows and then saturates.
  assign overflow = event_in & ~snapshot & (count_reg == MAX);

endmodule
`default_nettype wire

/* perf_mon_pkg.sv */
// Shared constants for the E1 performance monitor block.
`default_nettype none
package perf_mon_pkg;

  // Counters kept per link, in flag-vector order.
  localparam int NUM_CNT         = 9;
  localparam int CNT_LINE        = 0;
  localparam int CNT_FRAMING     = 1;
  localparam int CNT_CRC4        = 2;
  localparam int CNT_FAR_BLOCK   = 3;
  localparam int CNT_ALIGN_SHIFT = 4;
  localparam int CNT_SYNC_LOSS   = 5;
  localparam int CNT_PATTERN     = 6;
  localparam int CNT_NAT_FAR     = 7;
  localparam int CNT_NAT_CRC     = 8;

  // Width, first readout location and byte count of each counter.
  localparam int CNT_W     [NUM_CNT] = '{16, 12, 10, 10, 3, 5, 16, 10, 10};
  localparam int CNT_LOC   [NUM_CNT] = '{8, 2, 0, 12, 4, 5, 6, 14, 10};
  localparam int CNT_BYTES [NUM_CNT] = '{2, 2, 2, 2, 1, 1, 2, 2, 2};
  localparam int SNAP_W              = 16;

  // Register word indices; byte address is four times the index.
  localparam int          IDX_W               = 11;
  localparam int          AXI_ADDR_W          = 13;
  localparam logic [10:0] ACCESS_SELECT_IDX   = 11'h00e;
  localparam logic [10:0] ACCESS_READBACK_IDX = 11'h00f;
  localparam int          IDX_LINK_LSB        = 8;
  localparam logic [7:0]  UPDATE_CONTROL_OFF  = 8'hc2;
  localparam logic [7:0]  IRQ_EN_LOW_OFF      = 8'hc3;
  localparam logic [7:0]  IRQ_EN_HIGH_OFF     = 8'hc4;
  localparam logic [7:0]  FLAGS_LOW_OFF       = 8'hc5;
  localparam logic [7:0]  FLAGS_HIGH_OFF      = 8'hc6;

  // Field positions.
  localparam int SEL_ADDR_LSB    = 0;
  localparam int SEL_LINK_LSB    = 4;
  localparam int CTRL_AUTO_BIT   = 0;
  localparam int CTRL_MANUAL_BIT = 1;
  localparam int FLAG_HIGH_CNT   = 3;
  localparam int FLAG_LOW_CNT    = 6;

  // Reset values.
  localparam logic [6:0] SELECT_RST = 7'h00;
  localparam logic [1:0] CTRL_RST   = 2'h0;
  localparam logic [8:0] EN_RST     = 9'h000;
  localparam logic [8:0] FLAG_RST   = 9'h000;

  // Timing of the automatic snapshot.
  localparam int CLK_PERIOD_NS          = 50;
  localparam int SNAPSHOT_PERIOD_MS     = 1000;
  localparam int SNAPSHOT_PERIOD_CYCLES = SNAPSHOT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire
